/* core/lpcfg_controller.sv */
// Controller end: Wishbone registers take orders, the FSM drives the bus.
// Assumes a classic Wishbone master on sys_clk and the device on the link.
`timescale 1ns/100ps
`include "lpcfg_defines.svh"
module lpcfg_controller (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  lpcfg_link_if.ctrl link
);
  import lpcfg_pkg::*;

  // ****************************************
  // Bus decode
  // ****************************************
  lpcfg_state_type state_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic req;
  logic idle;
  logic take;
  logic hitMode;
  logic hitExt;
  logic hitAcc;
  logic hitStat;
  logic order;
  assign req = cyc_i && stb_i && !ack_q;
  assign idle = (state_q == LPCFG_IDLE);
  assign hitMode = (adr_i == `LPCFG_REG_MODE);
  assign hitExt = (adr_i == `LPCFG_REG_EXT);
  assign hitAcc = (adr_i == `LPCFG_REG_ACCESS);
  assign hitStat = (adr_i == `LPCFG_REG_STATUS);
  assign order = we_i && sel_i[0] && (hitMode || hitExt || hitAcc);
  // Orders wait for idle: ack is held back until the bus is free
  assign take = req && (!order || idle);

  // ****************************************
  // Order registers and link drive
  // ****************************************
  logic [6:0] mode_q;
  logic [7:0] ext_q;
  logic deepSleep_q;
  logic [3:0] cmd_q;
  logic [1:0] bank_q;
  logic [13:0] addr_q;
  logic [4:0] wait_q;
  logic [4:0] burstCyc;
  assign burstCyc = (mode_q[2:0] == `LPCFG_LEN_16) ? 5'h10 :
    (mode_q[2:0] == `LPCFG_LEN_8) ? 5'h08 :
    (mode_q[2:0] == `LPCFG_LEN_4) ? 5'h04 : 5'h02;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= LPCFG_IDLE;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      mode_q <= `LPCFG_MODE_RESET;
      ext_q <= `LPCFG_EXT_RESET;
      deepSleep_q <= 1'b0;
      cmd_q <= `LPCFG_CMD_NOP;
      bank_q <= 2'h0;
      addr_q <= 14'h0000;
      wait_q <= 5'h00;
    end else begin
      ack_q <= take;
      dat_q <= (take && hitStat) ? {24'h00_0000, 6'h00, deepSleep_q, !idle} :
        (take && hitMode) ? {25'h000_0000, mode_q} :
        (take && hitExt) ? {24'h00_0000, ext_q} : 32'h0000_0000;
      cmd_q <= `LPCFG_CMD_NOP;
      case (state_q)
        LPCFG_IDLE: begin
          if (take && order) begin
            state_q <= LPCFG_ISSUE;
            if (hitAcc) begin
              cmd_q <= dat_i[16] ? `LPCFG_CMD_WRITE : `LPCFG_CMD_READ;
              addr_q <= {4'h0, dat_i[9:0]};
              bank_q <= dat_i[13:12];
              // Hold off a load until data has cleared the pins
              wait_q <= burstCyc + 5'h03;
            end else begin
              cmd_q <= `LPCFG_CMD_LOAD;
              bank_q <= hitExt ? 2'h2 : 2'h0;
              addr_q <= hitExt ? {6'h00, dat_i[7:0] & ~`LPCFG_TEMP_FIELD_MASK} :
                {7'h00, dat_i[6:0]};
              wait_q <= 5'(`LPCFG_LOAD_GAP_CYC);
              if (hitExt) begin
                ext_q <= dat_i[7:0] & ~`LPCFG_TEMP_FIELD_MASK;
              end else begin
                mode_q <= dat_i[6:0];
              end
            end
          end
        end
        LPCFG_ISSUE: begin
          state_q <= LPCFG_WAIT;
        end
        LPCFG_WAIT: begin
          if (wait_q <= 5'h01) begin
            state_q <= LPCFG_IDLE;
          end else begin
            wait_q <= wait_q - 5'h01;
          end
        end
        default: begin
          state_q <= LPCFG_IDLE;
        end
      endcase
      // Status writes are acked in any state, so never dropped while busy
      if (take && we_i && hitStat && sel_i[0]) begin
        deepSleep_q <= dat_i[1];
      end
      // Device forgets its settings in deep sleep, shadows follow
      if (deepSleep_q) begin
        mode_q <= `LPCFG_MODE_RESET;
        ext_q <= `LPCFG_EXT_RESET;
      end
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign {link.csN, link.rasN, link.casN, link.weN} = cmd_q;
  assign link.bankSelLo = bank_q[0];
  assign link.bankSelHi = bank_q[1];
  assign link.addr = addr_q;
  assign link.deepSleep = deepSleep_q;
endmodule

/* core/lpcfg_defines.svh */
// Constants for the configuration-load link: command codes, field positions,
// reset values and timing counts. Assumes a 20 MHz sys_clk on both ends.
//
// What this block does
// - Load with both bank selects low: standard config
// - Standard config kept until reload or deep sleep
// - Config load never touches memory array contents
// - Controller loads only when idle, no burst running
// - Controller waits load gap after each load
// - Burst lengths 2, 4, 8, 16, both orders
// - Burst wraps inside aligned block of length
// - Low column bits give first location in block
// - Burst length applies to reads and writes
// - Setting selects sequential or interleaved order
// - Offset: (start+k) mod len, or start xor k
// - Read latency configurable to 2 or 3
// - First read data after edge n+1 or n+2
// - Normal mode needs zero address bits 7 upward
// - Controller avoids reserved upper bits; mode settings pass unchecked
// - Load with bank select high only: extended config
// - Extended config kept until reload or deep sleep
// - Extended config holds strength, temp and partial fields
// - Temperature refresh field writes are ignored
// - Partial select limits self refresh region
// - Strength setting: full, three-quarter, one-half
`ifndef LPCFG_DEFINES_SVH
`define LPCFG_DEFINES_SVH

// ****************************************
// Command codes {csN, rasN, casN, weN}
// ****************************************
`define LPCFG_CMD_NOP 4'h7
`define LPCFG_CMD_LOAD 4'h0
`define LPCFG_CMD_READ 4'h5
`define LPCFG_CMD_WRITE 4'h4

// ****************************************
// Configuration fields
// ****************************************
`define LPCFG_LEN_LSB 0
`define LPCFG_BT_BIT 3
`define LPCFG_RL_LSB 4
`define LPCFG_PARTIAL_LSB 0
`define LPCFG_TEMP_FIELD_LSB 3
`define LPCFG_STRENGTH_LSB 5
`define LPCFG_LEN_2 3'h1
`define LPCFG_LEN_4 3'h2
`define LPCFG_LEN_8 3'h3
`define LPCFG_LEN_16 3'h4
`define LPCFG_RL_2 3'h2
`define LPCFG_RL_3 3'h3
`define LPCFG_MODE_RESET 7'h32
`define LPCFG_EXT_RESET 8'h00
`define LPCFG_TEMP_FIELD_MASK 8'h18

// ****************************************
// Timing
// ****************************************
`define LPCFG_CLK_NS 50
`define LPCFG_LOAD_GAP_NS 15
`define LPCFG_LOAD_GAP_CYC \
  (((`LPCFG_LOAD_GAP_NS + `LPCFG_CLK_NS - 1) / `LPCFG_CLK_NS) < 1 ? 1 : \
  ((`LPCFG_LOAD_GAP_NS + `LPCFG_CLK_NS - 1) / `LPCFG_CLK_NS))

// ****************************************
// Controller register offsets
// ****************************************
`define LPCFG_REG_MODE 4'h0
`define LPCFG_REG_EXT 4'h4
`define LPCFG_REG_ACCESS 4'h8
`define LPCFG_REG_STATUS 4'hC

`endif

/* core/lpcfg_device.sv */
// Device end: configuration registers, burst column ordering, read latency.
// Assumes the controller drives the command bus on the same sys_clk.
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "lpcfg_defines.svh"
module lpcfg_device (
  input wire logic sys_clk,
  input wire logic reset,
  lpcfg_link_if.dev link,
  output logic [2:0] burstLen,
  output logic burstInterleaved,
  output logic [2:0] readLatency,
  output logic [2:0] outputStrength,
  output logic [2:0] partialRefreshSelect,
  output logic accValid,
  output logic accWrite,
  output logic [9:0] accCol,
  output logic rdValid,
  output logic [9:0] rdCol
);
  import lpcfg_pkg::*;

  // ****************************************
  // Command decode
  // ****************************************
  logic [6:0] mode_q;
  logic [7:0] ext_q;
  logic [3:0] cmd;
  logic isLoad;
  logic loadStd;
  logic loadExt;
  logic isAccess;
  assign cmd = {link.csN, link.rasN, link.casN, link.weN};
  assign isLoad = (cmd == `LPCFG_CMD_LOAD);
  assign loadStd = isLoad && !link.bankSelLo && !link.bankSelHi
    && (link.addr[13:7] == 7'h00);
  assign loadExt = isLoad && !link.bankSelLo && link.bankSelHi;
  assign isAccess = (cmd == `LPCFG_CMD_READ) || (cmd == `LPCFG_CMD_WRITE);

  // ****************************************
  // Configuration registers
  // ****************************************
  // Loads only touch these flops, never the array side
  always_ff @(posedge sys_clk) begin
    if (reset || link.deepSleep) begin
      mode_q <= `LPCFG_MODE_RESET;
      ext_q <= `LPCFG_EXT_RESET;
    end else begin
      if (loadStd) begin
        mode_q <= link.addr[6:0];
      end
      if (loadExt) begin
        ext_q <= link.addr[7:0] & ~`LPCFG_TEMP_FIELD_MASK;
      end
    end
  end

  assign burstLen = mode_q[`LPCFG_LEN_LSB +: 3];
  assign burstInterleaved = mode_q[`LPCFG_BT_BIT];
  assign readLatency = mode_q[`LPCFG_RL_LSB +: 3];
  assign outputStrength = ext_q[`LPCFG_STRENGTH_LSB +: 3];
  assign partialRefreshSelect = ext_q[`LPCFG_PARTIAL_LSB +: 3];

  // ****************************************
  // Burst column generator
  // ****************************************
  logic [9:0] start_q;
  logic [3:0] k_q;
  logic [4:0] left_q;
  logic write_q;
  logic [3:0] mask;
  logic [4:0] lenCount;
  logic [3:0] offset;
  logic [9:0] colNow;
  logic busy;
  // Unused length codes fall back to two
  assign mask = (burstLen == `LPCFG_LEN_16) ? 4'hF :
    (burstLen == `LPCFG_LEN_8) ? 4'h7 :
    (burstLen == `LPCFG_LEN_4) ? 4'h3 : 4'h1;
  assign lenCount = {1'b0, mask} + 5'h01;
  assign offset = burstInterleaved ? ((start_q[3:0] ^ k_q) & mask)
    : ((start_q[3:0] + k_q) & mask);
  assign colNow = {start_q[9:4], (start_q[3:0] & ~mask) | offset};
  assign busy = (left_q != 5'h00);

  // A new access cuts the running burst short
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      start_q <= 10'h000;
      k_q <= 4'h0;
      left_q <= 5'h00;
      write_q <= 1'b0;
    end else if (isAccess) begin
      start_q <= link.addr[9:0];
      k_q <= 4'h0;
      left_q <= lenCount;
      write_q <= !link.weN ? 1'b1 : 1'b0;
    end else if (busy) begin
      k_q <= k_q + 4'h1;
      left_q <= left_q - 5'h01;
    end
  end

  // ****************************************
  // Access and read-latency outputs
  // ****************************************
  logic accValid_q;
  logic accWrite_q;
  logic [9:0] accCol_q;
  logic rd1Valid_q;
  logic [9:0] rd1Col_q;
  logic rdValid_q;
  logic [9:0] rdCol_q;
  logic rdNow;
  logic latThree;
  assign rdNow = busy && !write_q;
  assign latThree = (readLatency == `LPCFG_RL_3);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      accValid_q <= 1'b0;
      accWrite_q <= 1'b0;
      accCol_q <= 10'h000;
      rd1Valid_q <= 1'b0;
      rd1Col_q <= 10'h000;
      rdValid_q <= 1'b0;
      rdCol_q <= 10'h000;
    end else begin
      accValid_q <= busy;
      accWrite_q <= busy && write_q;
      accCol_q <= colNow;
      rd1Valid_q <= rdNow;
      rd1Col_q <= colNow;
      rdValid_q <= latThree ? rd1Valid_q : rdNow;
      rdCol_q <= latThree ? rd1Col_q : colNow;
    end
  end

  assign accValid = accValid_q;
  assign accWrite = accWrite_q;
  assign accCol = accCol_q;
  assign rdValid = rdValid_q;
  assign rdCol = rdCol_q;
endmodule

/* core/lpcfg_link_if.sv */
// Command bus between memory controller and device, one modport per end.
// Assumes both ends share sys_clk; commands are taken on its rising edge.
`timescale 1ns/100ps
interface lpcfg_link_if;
  logic csN;
  logic rasN;
  logic casN;
  logic weN;
  logic bankSelLo;
  logic bankSelHi;
  logic [13:0] addr;
  logic deepSleep;
  modport ctrl (output csN, rasN, casN, weN, bankSelLo, bankSelHi, addr, deepSleep);
  modport dev (input csN, rasN, casN, weN, bankSelLo, bankSelHi, addr, deepSleep);
endinterface

/* core/lpcfg_pkg.sv */
// Types shared by both ends of the configuration-load link.
// Assumes lpcfg_defines.svh supplies the numeric constants.
package lpcfg_pkg;
  typedef enum logic [1:0] {
    LPCFG_IDLE = 2'h0,
    LPCFG_ISSUE = 2'h1,
    LPCFG_WAIT = 2'h3
  } lpcfg_state_type;
endpackage

/* dv/lpcfg_assertions.sv */
// Checker on the link command bus between controller and device.
// Assumes one sys_clk domain with synchronous active-high reset.
`timescale 1ns/100ps
`include "lpcfg_defines.svh"
module lpcfg_assertions (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic bankSelLo,
  input wire logic bankSelHi,
  input wire logic [13:0] addr,
  input wire logic deepSleep
);
  wire logic [3:0] cmd = {csN, rasN, casN, weN};
  wire logic isLoad = cmd == `LPCFG_CMD_LOAD;
  wire logic isAcc = cmd == `LPCFG_CMD_READ || cmd == `LPCFG_CMD_WRITE;
  // ****************
  // Burst tracking
  // ****************
  logic [2:0] lenCode_q;
  logic [4:0] accLeft_q;
  wire logic [4:0] accLen = (lenCode_q == `LPCFG_LEN_16) ? 5'h10 :
    (lenCode_q == `LPCFG_LEN_8) ? 5'h08 :
    (lenCode_q == `LPCFG_LEN_4) ? 5'h04 : 5'h02;
  // Length as the device holds it, so the end of each burst is known
  always_ff @(posedge sys_clk) begin
    if (reset || deepSleep) begin
      lenCode_q <= 3'(`LPCFG_MODE_RESET);
    end else if (isLoad && !bankSelLo && !bankSelHi && addr[13:7] == 7'h00) begin
      lenCode_q <= addr[2:0];
    end
    if (reset) begin
      accLeft_q <= 5'h00;
    end else if (isAcc) begin
      accLeft_q <= accLen;
    end else if (accLeft_q != 5'h00) begin
      accLeft_q <= accLeft_q - 5'h01;
    end
  end
  // ****************
  // Link checks
  // ****************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_load_gap: assert property (isLoad |=> cmd == `LPCFG_CMD_NOP)
    else $error("command inside load gap");
  a_acc_after_load: assert property (isAcc |-> !$past(isLoad))
    else $error("access right after load");
  a_burst_idle: assert property (isAcc |=> !isLoad [*4])
    else $error("load while burst runs");
  a_load_no_burst: assert property (isLoad |-> accLeft_q == 5'h00)
    else $error("load before burst end");
  a_acc_single: assert property (isAcc |=> cmd == `LPCFG_CMD_NOP)
    else $error("access not followed by idle");
  a_std_upper: assert property (isLoad && !bankSelHi |-> addr[13:7] == 7'h00)
    else $error("standard load with upper bits set");
  a_ext_upper: assert property (isLoad && bankSelHi |-> addr[13:8] == 6'h00)
    else $error("extended load with upper bits set");
  a_bank_lo: assert property (isLoad |-> !bankSelLo)
    else $error("load with low bank select set");
  a_cmd_legal: assert property (cmd inside {4'h7, 4'h0, 4'h5, 4'h4})
    else $error("unexpected command code");
  c_sleep: cover property ($rose(deepSleep));
endmodule

/* dv/tb.sv */
// Bench: controller and device joined by the link, driven over Wishbone.
// Assumes lpcfg_defines.svh is on the include path.
`timescale 1ns/100ps
`include "lpcfg_defines.svh"
module tb;
  typedef struct {logic [6:0] mode; logic [9:0] col; logic wr; int n; int lat;} lpcfg_row_type;
  logic sys_clk, reset, cyc, stb, we, ack, accValid, accWrite, rdValid, inter, wrSeen;
  logic [3:0] adr, sel;
  logic [31:0] wDat, rDat, r;
  logic [2:0] burstLen, readLatency, strength, partial;
  logic [9:0] accCol, rdCol;
  logic [9:0] accQ[$], rdQ[$];
  int fail_count, compares, tick, cmdAt, rdAt;
  // Mode, start column, write, beats, latency
  lpcfg_row_type rows[8] = '{
    '{7'h21, 10'h3FF, 0, 2, 2}, '{7'h29, 10'h000, 0, 2, 2},
    '{7'h32, 10'h006, 1, 4, 3}, '{7'h3A, 10'h005, 0, 4, 3},
    '{7'h23, 10'h10E, 0, 8, 2}, '{7'h2B, 10'h003, 1, 8, 2},
    '{7'h3C, 10'h2A9, 0, 16, 3}, '{7'h34, 10'h00F, 0, 16, 3}};
  lpcfg_link_if link();
  wire logic [3:0] linkCmd = {link.csN, link.rasN, link.casN, link.weN};
  lpcfg_controller u_lpcfg_controller (.sys_clk(sys_clk), .reset(reset), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wDat), .sel_i(sel), .dat_o(rDat),
    .ack_o(ack), .link(link));
  lpcfg_device u_lpcfg_device (.sys_clk(sys_clk), .reset(reset), .link(link),
    .burstLen(burstLen), .burstInterleaved(inter), .readLatency(readLatency),
    .outputStrength(strength), .partialRefreshSelect(partial), .accValid(accValid),
    .accWrite(accWrite), .accCol(accCol), .rdValid(rdValid), .rdCol(rdCol));
  lpcfg_assertions u_lpcfg_assertions (.sys_clk(sys_clk), .reset(reset), .csN(link.csN),
    .rasN(link.rasN), .casN(link.casN), .weN(link.weN), .bankSelLo(link.bankSelLo),
    .bankSelHi(link.bankSelHi), .addr(link.addr), .deepSleep(link.deepSleep));
  // ****************
  // Helpers
  // ****************
  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Old values read at the edge, design flops land later
  always @(posedge sys_clk) begin
    tick <= tick + 1;
    if (linkCmd == `LPCFG_CMD_READ) cmdAt <= tick;
    if (accValid) accQ.push_back(accCol);
    if (accValid) wrSeen <= accWrite;
    if (rdValid && rdQ.size() == 0) rdAt <= tick;
    if (rdValid) rdQ.push_back(rdCol);
  end
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Ack and data taken at the rising edge, request released by that edge
  task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wDat <= d;
    sel <= 4'hF;
    do @(posedge sys_clk); while (ack !== 1'b1);
    r = rDat;
    cyc <= 0;
    stb <= 0;
  endtask
  function automatic logic [9:0] beat(logic [9:0] s, int n, logic il, int k);
    logic [9:0] m = 10'(n - 1);
    return (s & ~m) | ((il ? s ^ 10'(k) : s + 10'(k)) & m);
  endfunction
  task automatic checkBurst(lpcfg_row_type t);
    check(accQ.size(), t.n);
    foreach (accQ[k]) check(accQ[k], beat(t.col, t.n, t.mode[3], k));
    check(wrSeen, t.wr);
    check(rdQ.size(), t.wr ? 0 : t.n);
    foreach (rdQ[k]) check(rdQ[k], beat(t.col, t.n, t.mode[3], k));
    if (!t.wr) check(rdAt - cmdAt, t.lat);
    check(inter, t.mode[3]);
    accQ.delete();
    rdQ.delete();
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    repeat (3000) @(posedge sys_clk);
    fail_count++;
    print_verdict();
  end
  initial begin
    reset = 1;
    {cyc, stb, we, adr, wDat, sel} = '0;
    repeat (6) @(posedge sys_clk);
    reset <= 0;
    wb(0, `LPCFG_REG_MODE, 0);
    check(r, 32'h32);
    check(readLatency, `LPCFG_RL_3);
    check(burstLen, `LPCFG_LEN_4);
    $display("reset test done");
    foreach (rows[i]) begin
      wb(1, `LPCFG_REG_MODE, rows[i].mode);
      wb(1, `LPCFG_REG_ACCESS, {15'h0, rows[i].wr, 6'h0, rows[i].col});
      repeat (24) @(posedge sys_clk);
      checkBurst(rows[i]);
      $display("row %0d done", i);
    end
    // Load ordered mid-burst must wait for the burst
    wb(1, `LPCFG_REG_ACCESS, 32'h100);
    wb(1, `LPCFG_REG_MODE, 32'h21);
    repeat (24) @(posedge sys_clk);
    check(accQ.size(), 16);
    check(burstLen, `LPCFG_LEN_2);
    $display("busy load test done");
    wb(1, `LPCFG_REG_EXT, 32'hFF);
    wb(0, `LPCFG_REG_EXT, 0);
    check(r, 32'hE7);
    check(strength, 3'h7);
    check(partial, 3'h7);
    check(burstLen, `LPCFG_LEN_2);
    $display("extended test done");
    wb(1, `LPCFG_REG_STATUS, 32'h2);
    repeat (4) @(posedge sys_clk);
    check(burstLen, `LPCFG_LEN_4);
    check(strength, 3'h0);
    wb(0, `LPCFG_REG_STATUS, 0);
    check(r, 32'h2);
    wb(0, `LPCFG_REG_MODE, 0);
    check(r, 32'h32);
    wb(1, `LPCFG_REG_STATUS, 0);
    wb(1, `LPCFG_REG_MODE, 32'h23);
    repeat (4) @(posedge sys_clk);
    check(burstLen, `LPCFG_LEN_8);
    $display("deep sleep test done");
    // Reset again in mid-run: settings fall back to their reset values
    reset <= 1;
    repeat (2) @(posedge sys_clk);
    reset <= 0;
    wb(0, `LPCFG_REG_MODE, 0);
    check(r, 32'h32);
    check(burstLen, `LPCFG_LEN_4);
    check(accValid, 1'b0);
    $display("mid-run reset test done");
    print_verdict();
  end
endmodule
